// File: design/hbdc_pkg.sv
/*
  hbdc_pkg: command codes, field layout, reset values and types for the host buffer transfer setup and byte counter.
  assumes one clock domain; every user writes hbdc_pkg::name.
*/
package hbdc_pkg;

  // processor command codes, read and write
  localparam logic [7:0] CMD_SETUP_RD = 8'h21;
  localparam logic [7:0] CMD_SETUP_WR = 8'hA1;
  localparam logic [7:0] CMD_COUNT_RD = 8'h22;
  localparam logic [7:0] CMD_COUNT_WR = 8'hA2;
  localparam logic [7:0] CMD_EVENT_RD = 8'h24;
  localparam logic [7:0] CMD_EVENT_WR = 8'hA4;

  localparam int DATA_W = 16;
  localparam int SETUP_W = 8;
  localparam int BEAT_W = 4;

  localparam int ALL_DONE_BIT = 2;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // one 16-bit word moves two bytes
  localparam logic [15:0] BYTES_PER_WORD = 16'h0002;

  localparam logic [1:0] BURST_ONE = 2'h0;
  localparam logic [1:0] BURST_FOUR = 2'h1;
  localparam logic [1:0] BURST_EIGHT = 2'h2;
  localparam logic [BEAT_W-1:0] BEATS_ONE = 4'h1;
  localparam logic [BEAT_W-1:0] BEATS_FOUR = 4'h4;
  localparam logic [BEAT_W-1:0] BEATS_EIGHT = 4'h8;

  localparam logic [2:0] BUF_ISO_A = 3'h0;
  localparam logic [2:0] BUF_ISO_B = 3'h1;
  localparam logic [2:0] BUF_PERIODIC = 3'h2;
  localparam logic [2:0] BUF_ASYNC = 3'h3;
  localparam int BUF_DIRECT_BIT = 2;

  typedef struct packed {
    logic count_enable_bit;
    logic [1:0] burst_length_sel;
    logic transfer_enable_bit;
    logic [2:0] buffer_sel;
    logic direction_sel;
  } hbdc_setup_s;

  localparam hbdc_setup_s SETUP_RESET = '0;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [DATA_W-1:0] wdata;
  } hbdc_access_s;

  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_ACTIVE = 2'b01,
    REQ_GAP = 2'b11
  } hbdc_req_e;

  function automatic logic [BEAT_W-1:0] burst_beats(input logic [1:0] sel);
    unique case (sel)
      BURST_FOUR: burst_beats = BEATS_FOUR;
      BURST_EIGHT: burst_beats = BEATS_EIGHT;
      default: burst_beats = BEATS_ONE;
    endcase
  endfunction

endpackage

// File: design/hbdc_byte_counter.sv
/*
  hbdc_byte_counter: 16-bit byte count with load, two-byte decrement and a done pulse on reaching zero.
  assumes load and decrement strobes are single-cycle and on clk_sys.
*/
`timescale 1ns/1ps
module hbdc_byte_counter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic dec,
  output logic [15:0] count,
  output logic done
);
  logic [15:0] count_q, count_d;
  logic done_q, done_d;

  always_comb begin
    count_d = count_q;
    done_d = 1'b0;
    if (load) begin
      count_d = load_val;
    end else if (dec && count_q != hbdc_pkg::COUNT_RESET) begin
      // odd remainder ends on the last word
      if (count_q <= hbdc_pkg::BYTES_PER_WORD) begin
        count_d = hbdc_pkg::COUNT_RESET;
        done_d = 1'b1;
      end else begin
        count_d = count_q - hbdc_pkg::BYTES_PER_WORD;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= hbdc_pkg::COUNT_RESET;
      done_q <= 1'b0;
    end else begin
      count_q <= count_d;
      done_q <= done_d;
    end
  end

  assign count = count_q;
  assign done = done_q;
endmodule // hbdc_byte_counter

// File: design/hbdc_top.sv
/*
  hbdc_top: transfer setup register, byte counter, request/acknowledge burst control and the all-done event flag.
  assumes a command-coded processor access port on clk_sys and an external dma acknowledge pin that is synchronised here.
*/
// How it works
// - the request output rises only once transfers are enabled, counting is enabled and the count is non-zero.
// - burst length 00 gives one beat, 01 four beats, 10 eight beats, 11 is reserved.
// - the 16-bit byte count holds the bytes to move, for both programmed and dma transfers.
// - a count is loaded whether or not count enable is set, but steps down only while count enable is set.
// - reaching the count raises a done pulse that sets the all-done flag and updates buffer status.
// - the byte count is read with code 22 and written with code A2.
// - the setup register is read with code 21 and written with code A1.
// - event flags stay set after a read and clear only on a write of 1 to their bit.
`timescale 1ns/1ps
module hbdc_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire hbdc_pkg::hbdc_access_s acc,
  output logic [15:0] acc_rdata,
  output logic acc_rvalid,
  input wire logic dack_n_pin,
  input wire logic pio_word_strobe,
  output logic transfer_request_out,
  output logic [2:0] buffer_sel,
  output logic direct_addr_mode,
  output logic direction_sel,
  output logic transfer_done_pulse,
  output logic buffer_status_update,
  output logic all_done_flag
);
  hbdc_pkg::hbdc_setup_s setup_q, setup_d;
  logic all_done_q, all_done_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  hbdc_pkg::hbdc_req_e state_q, state_d;
  logic [hbdc_pkg::BEAT_W-1:0] beats_q, beats_d;
  logic dack_s1_q, dack_s2_q, dack_s3_q;
  logic [15:0] count;
  logic done;
  logic go, dack_word, count_load, count_dec, wr_event;

  // acknowledge pin crosses in; falling edge taken between the second and third stages
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dack_s1_q <= 1'b1;
      dack_s2_q <= 1'b1;
      dack_s3_q <= 1'b1;
    end else begin
      dack_s1_q <= dack_n_pin;
      dack_s2_q <= dack_s1_q;
      dack_s3_q <= dack_s2_q;
    end
  end
  assign dack_word = dack_s3_q && !dack_s2_q && state_q == hbdc_pkg::REQ_ACTIVE;

  assign count_load = acc.valid && acc.code == hbdc_pkg::CMD_COUNT_WR;
  // count only steps down while counting is enabled; a load is taken regardless
  assign count_dec = setup_q.count_enable_bit && (dack_word || pio_word_strobe);
  assign wr_event = acc.valid && acc.code == hbdc_pkg::CMD_EVENT_WR;

  hbdc_byte_counter u_counter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(count_load),
    .load_val(acc.wdata),
    .dec(count_dec),
    .count(count),
    .done(done)
  );

  // register file and event flag
  always_comb begin
    setup_d = setup_q;
    all_done_d = all_done_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (acc.valid && acc.code == hbdc_pkg::CMD_SETUP_WR) begin
      setup_d = acc.wdata[hbdc_pkg::SETUP_W-1:0];
    end
    if (wr_event && acc.wdata[hbdc_pkg::ALL_DONE_BIT]) begin
      all_done_d = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (done) begin
      all_done_d = 1'b1;
    end
    if (acc.valid && !acc.code[7]) begin
      rvalid_d = 1'b1;
      unique case (acc.code)
        hbdc_pkg::CMD_SETUP_RD: rdata_d = {8'h00, setup_q};
        hbdc_pkg::CMD_COUNT_RD: rdata_d = count;
        hbdc_pkg::CMD_EVENT_RD: rdata_d = 16'(all_done_q) << hbdc_pkg::ALL_DONE_BIT;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= hbdc_pkg::SETUP_RESET;
      all_done_q <= 1'b0;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      setup_q <= setup_d;
      all_done_q <= all_done_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // request burst control
  assign go = setup_q.count_enable_bit && setup_q.transfer_enable_bit &&
              count != hbdc_pkg::COUNT_RESET;

  always_comb begin
    state_d = state_q;
    beats_d = beats_q;
    unique case (state_q)
      hbdc_pkg::REQ_IDLE: begin
        beats_d = '0;
        if (go) begin
          state_d = hbdc_pkg::REQ_ACTIVE;
        end
      end
      hbdc_pkg::REQ_ACTIVE: begin
        if (!go || done) begin
          state_d = hbdc_pkg::REQ_IDLE;
        end else if (count_dec && count <= hbdc_pkg::BYTES_PER_WORD) begin
          // last word: drop now, else the request stands a cycle with no count left
          state_d = hbdc_pkg::REQ_IDLE;
        end else if (dack_word) begin
          beats_d = beats_q + 4'h1;
          // drop the request for one cycle after a full burst
          if (beats_q + 4'h1 >= hbdc_pkg::burst_beats(setup_q.burst_length_sel)) begin
            state_d = hbdc_pkg::REQ_GAP;
          end
        end
      end
      hbdc_pkg::REQ_GAP: begin
        beats_d = '0;
        state_d = go ? hbdc_pkg::REQ_ACTIVE : hbdc_pkg::REQ_IDLE;
      end
      default: begin
        state_d = hbdc_pkg::REQ_IDLE;
        beats_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hbdc_pkg::REQ_IDLE;
      beats_q <= '0;
    end else begin
      state_q <= state_d;
      beats_q <= beats_d;
    end
  end

  assign transfer_request_out = state_q == hbdc_pkg::REQ_ACTIVE;
  assign buffer_sel = setup_q.buffer_sel;
  assign direct_addr_mode = setup_q.buffer_sel[hbdc_pkg::BUF_DIRECT_BIT];
  assign direction_sel = setup_q.direction_sel;
  assign transfer_done_pulse = done;
  assign buffer_status_update = done;
  assign all_done_flag = all_done_q;
  assign acc_rdata = rdata_q;
  assign acc_rvalid = rvalid_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence last_beat_s;
    state_q == hbdc_pkg::REQ_ACTIVE && dack_word && go && !done &&
    beats_q + 4'h1 == hbdc_pkg::burst_beats(setup_q.burst_length_sel);
  endsequence

  req_needs_go_a: assert property (transfer_request_out |-> setup_q.count_enable_bit && count != 16'h0000)
    else $error("request without count enable or count");
  req_rises_a: assert property (state_q == hbdc_pkg::REQ_IDLE && go |=> transfer_request_out)
    else $error("request did not rise when enabled");
  burst_gap_a: assert property (last_beat_s |=> !transfer_request_out ##1 (go -> transfer_request_out))
    else $error("burst length not honoured");
  count_load_a: assert property (count_load |=> count == $past(acc.wdata))
    else $error("byte count load wrong");
  count_step_a: assert property (count_dec && !count_load && count > 16'h0002 |=> count == $past(count) - 16'h0002)
    else $error("byte count step wrong");
  done_flag_a: assert property (count_dec && !count_load && count inside {16'h0001, 16'h0002}
    |=> transfer_done_pulse ##1 all_done_flag)
    else $error("done did not set flag");
  flag_sticky_a: assert property (all_done_flag && !(wr_event && acc.wdata[2]) |=> all_done_flag)
    else $error("all-done flag lost without clear");
  flag_clear_a: assert property (wr_event && acc.wdata[2] && !done |=> !all_done_flag)
    else $error("all-done flag not cleared");
  setup_read_a: assert property (acc.valid && acc.code == 8'h21 |=> acc_rvalid && acc_rdata == {8'h00, setup_q})
    else $error("setup read data wrong");
  direct_mode_a: assert property (acc.valid && acc.code == hbdc_pkg::CMD_SETUP_WR |=>
    buffer_sel == $past(acc.wdata[3:1]) && direct_addr_mode == $past(acc.wdata[3]) &&
    direction_sel == $past(acc.wdata[0]))
    else $error("buffer select decode wrong");
endmodule // hbdc_top

// File: tb/hbdc_dma_model.sv
/*
  hbdc_dma_model: external dma controller that answers the request with active-low acknowledges.
  assumes request is sampled on clk_sys; slow stretches the gap between beats.
*/
`timescale 1ns/1ps
module hbdc_dma_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req,
  input wire logic slow,
  output logic dack_n_pin
);
  int cnt_q;
  // pin low three clocks, then high at least three, so the synchroniser sees every beat
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dack_n_pin <= 1'b1;
      cnt_q <= 0;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == (slow ? 7 : 3)) begin
        dack_n_pin <= 1'b1;
      end
    end else if (req === 1'b1) begin
      dack_n_pin <= 1'b0;
      cnt_q <= slow ? 9 : 5;
    end
  end
endmodule // hbdc_dma_model

// File: tb/hbdc_top_test.sv
/*
  hbdc_top_test: register, pio and dma burst tests of hbdc_top through its command-coded access port.
  assumes hbdc_dma_model stands in for the external dma controller.
*/
`timescale 1ns/1ps
module hbdc_top_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  hbdc_pkg::hbdc_access_s acc = '0;
  logic pio_word_strobe = 1'b0;
  logic slow = 1'b0;
  logic [15:0] acc_rdata;
  logic acc_rvalid, dack_n_pin, req, direct_addr_mode, direction_sel, done, stat, flag, req_q;
  logic [2:0] buffer_sel;
  int err_count = 0;
  int checks = 0;
  int done_n, stat_n, rise_n;
  int cyc = 0;

  always #10 clk_sys = ~clk_sys;

  hbdc_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .acc(acc), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .dack_n_pin(dack_n_pin), .pio_word_strobe(pio_word_strobe), .transfer_request_out(req),
    .buffer_sel(buffer_sel), .direct_addr_mode(direct_addr_mode), .direction_sel(direction_sel),
    .transfer_done_pulse(done), .buffer_status_update(stat), .all_done_flag(flag));

  hbdc_dma_model dma_u (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .slow(slow), .dack_n_pin(dack_n_pin));

  always @(posedge clk_sys) begin
    req_q <= req;
    if (done === 1'b1) done_n++;
    if (stat === 1'b1) stat_n++;
    if (req === 1'b1 && req_q !== 1'b1) rise_n++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one access: valid for a single edge, outputs settled on return
  task automatic wr(input logic [7:0] code, input logic [15:0] wd);
    @(posedge clk_sys);
    acc <= {1'b1, code, wd};
    @(posedge clk_sys);
    acc.valid <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    wr(code, 16'h0000);
    chk({15'h0, acc_rvalid}, 16'h0001);
    chk(acc_rdata, exp);
  endtask

  task automatic pio_word();
    @(posedge clk_sys);
    pio_word_strobe <= 1'b1;
    @(posedge clk_sys);
    pio_word_strobe <= 1'b0;
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk({15'h0, flag}, 16'h0001);
    chk(done_n[15:0], 16'h0001);
    chk(stat_n[15:0], 16'h0001);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(hbdc_pkg::CMD_SETUP_RD, 16'h0000);
    rd(hbdc_pkg::CMD_COUNT_RD, 16'h0000);
    rd(hbdc_pkg::CMD_EVENT_RD, 16'h0000);
    rd(8'h33, 16'h0000);
    $display("test reset values done");
    // upper byte written as ones must read back zero
    for (int i = 0; i < 16; i++) begin
      wr(hbdc_pkg::CMD_SETUP_WR, {8'hFF, 4'h2, i[3:0]});
      chk({13'h0, buffer_sel}, {13'h0, i[3:1]});
      chk({15'h0, direct_addr_mode}, {15'h0, i[3]});
      chk({15'h0, direction_sel}, {15'h0, i[0]});
      rd(hbdc_pkg::CMD_SETUP_RD, {8'h00, 4'h2, i[3:0]});
    end
    $display("test setup fields done");
    rise_n = 0;
    wr(hbdc_pkg::CMD_COUNT_WR, 16'h0004);
    wr(hbdc_pkg::CMD_SETUP_WR, 16'h0010);
    pio_word();
    repeat (20) @(posedge clk_sys);
    rd(hbdc_pkg::CMD_COUNT_RD, 16'h0004);
    chk(rise_n[15:0], 16'h0000);
    wr(hbdc_pkg::CMD_COUNT_WR, 16'h0000);
    wr(hbdc_pkg::CMD_SETUP_WR, 16'h0090);
    repeat (20) @(posedge clk_sys);
    chk(rise_n[15:0], 16'h0000);
    $display("test request gating done");
    done_n = 0;
    stat_n = 0;
    wr(hbdc_pkg::CMD_SETUP_WR, 16'h0080);
    wr(hbdc_pkg::CMD_COUNT_WR, 16'h0004);
    pio_word();
    pio_word();
    wait_flag();
    rd(hbdc_pkg::CMD_COUNT_RD, 16'h0000);
    rd(hbdc_pkg::CMD_EVENT_RD, 16'h0004);
    rd(hbdc_pkg::CMD_EVENT_RD, 16'h0004);
    wr(hbdc_pkg::CMD_EVENT_WR, 16'h0004);
    rd(hbdc_pkg::CMD_EVENT_RD, 16'h0000);
    $display("test pio count done");
    // four words per run: bursts of one, four, eight and reserved
    for (int b = 0; b < 4; b++) begin
      rise_n = 0;
      done_n = 0;
      stat_n = 0;
      slow <= (b == 3);
      wr(hbdc_pkg::CMD_COUNT_WR, 16'h0008);
      // 16-bit port, so the eight-beat burst is a legal setting here
      wr(hbdc_pkg::CMD_SETUP_WR, {8'h00, 1'b1, b[1:0], 1'b1, 4'h0});
      wait_flag();
      chk(rise_n[15:0], (b == 1 || b == 2) ? 16'h0001 : 16'h0004);
      rd(hbdc_pkg::CMD_COUNT_RD, 16'h0000);
      wr(hbdc_pkg::CMD_SETUP_WR, 16'h0000);
      wr(hbdc_pkg::CMD_EVENT_WR, 16'h0004);
      chk({15'h0, flag}, 16'h0000);
    end
    $display("test dma bursts done");
    final_report();
  end
endmodule // hbdc_top_test
